// ===== src/ram_arb_map.svh
// Offsets, reset values and timing counts for the global RAM bus arbiter.
// Assumes a 125 MHz sys_clk; every count below is derived from that period.
`ifndef RAM_ARB_MAP_SVH
`define RAM_ARB_MAP_SVH

// -------------------------------------------------------------
// Sizes
// -------------------------------------------------------------
`define RA_ADDR_W        16
`define RA_DATA_W        16
`define RA_NUM_REQ       5
`define RA_CPU_IDX       3'h0
`define RA_FILT1_IDX     3'h1
`define RA_FILT2_IDX     3'h2
`define RA_XFORM_IDX     3'h3
`define RA_FLOAT_IDX     3'h4

// -------------------------------------------------------------
// Addresses and reset values
// -------------------------------------------------------------
`define RA_IRQ_ADDR      16'hffff
`define RA_GNT_RST       5'h1f
`define RA_CNT_RST       16'h0000

// -------------------------------------------------------------
// Timing
// -------------------------------------------------------------
`define RA_CLK_NS        8
`define RA_GNT_NS        410
`define RA_DVALID_NS     80
`define RA_SETUP_NS      30
`define RA_HOLD_NS       20
`define RA_GNT_CYC       (`RA_GNT_NS / `RA_CLK_NS)
`define RA_DVALID_CYC    ((`RA_DVALID_NS + `RA_CLK_NS - 1) / `RA_CLK_NS)
`define RA_SETUP_CYC     ((`RA_SETUP_NS + `RA_CLK_NS - 1) / `RA_CLK_NS)
`define RA_HOLD_CYC      ((`RA_HOLD_NS + `RA_CLK_NS - 1) / `RA_CLK_NS)
`define RA_SAMPLE_CYC    (`RA_DVALID_CYC + 1)

`endif

// ===== src/ram_arb_pkg.sv
// Types shared by the global RAM arbiter, its requester model and its bench.
// Assumes ram_arb_map.svh supplies the widths.
`include "ram_arb_map.svh"

package ram_arb_pkg;

   // -------------------------------------------------------------
   // Arbiter states
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE    = 4'b0001,
      S_GRANT   = 4'b0010,
      S_RELEASE = 4'b0100,
      S_CLEAR   = 4'b1000
   } arb_state_e;

   // -------------------------------------------------------------
   // One sample of the shared bus, true polarity
   // -------------------------------------------------------------
   typedef struct packed {
      logic                  rw_n;
      logic [`RA_ADDR_W-1:0] addr;
      logic [`RA_DATA_W-1:0] data;
   } bus_sample_s;

endpackage

// ===== src/ram_arb_mem.sv
// Global RAM storage: one write or one read port, registered read data.
// Assumes the caller never asks for read and write in one cycle.
`timescale 1ns/1ps

module ram_arb_mem #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input  wire logic              sys_clk,
   input  wire logic              ce,
   input  wire logic              we,
   input  wire logic              re,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic      [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

   // No reset: contents survive system reset and are wiped by a sweep
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (we) begin
            mem_ff[addr] <= wdata;
         end
         if (re) begin
            rdata <= mem_ff[addr];
         end
      end
   end

endmodule // ram_arb_mem

// ===== src/global_ram_bus_arbiter.sv
// Global RAM with its bus arbiter: five requesters share one memory bus.
// Assumes all bus pins are asynchronous to sys_clk and are resynchronised.
`timescale 1ns/1ps
`include "ram_arb_map.svh"

module global_ram_bus_arbiter (
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   input  wire logic                  ce,
   input  wire logic                  cpu_mem_req_n,
   input  wire logic                  filt1_mem_req_n,
   input  wire logic                  filt2_mem_req_n,
   input  wire logic                  transform_mem_req_n,
   input  wire logic                  float_mem_req_n,
   output logic                       cpu_mem_gnt_n,
   output logic                       filt1_mem_gnt_n,
   output logic                       filt2_mem_gnt_n,
   output logic                       transform_mem_gnt_n,
   output logic                       float_mem_gnt_n,
   input  wire logic                  shared_read_write_n,
   input  wire logic [16:1]           shared_addr_n,
   input  wire logic [`RA_DATA_W-1:0] shared_data_n_rx,
   output logic      [`RA_DATA_W-1:0] shared_data_n_tx,
   output logic                       shared_data_drive,
   output logic                       shared_data_strobe_n,
   input  wire logic                  ram_dedicated_reset_n,
   output logic                       ram_irq_n_level,
   output logic                       ram_irq_drive
);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [4:0] one_hot(input logic [2:0] idx);
      one_hot = 5'h01 << idx;
   endfunction

   // Round robin: start searching just after the last owner
   function automatic logic [2:0] pick_next(input logic [4:0] req, input logic [2:0] last);
      logic       found;
      logic [2:0] j;
      found     = 1'b0;
      pick_next = last;
      for (int k = 1; k <= `RA_NUM_REQ; k++) begin
         j = 3'((int'(last) + k) % `RA_NUM_REQ);
         if (!found && req[j]) begin
            pick_next = j;
            found     = 1'b1;
         end
      end
   endfunction

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [4:0]              req_meta_ff;
   logic [4:0]              req_act_ff;
   logic                    rst_meta_ff;
   logic                    ram_rst_ff;
   ram_arb_pkg::bus_sample_s bus_meta_ff;
   ram_arb_pkg::bus_sample_s bus_ff;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         req_meta_ff <= 5'h00;
         req_act_ff  <= 5'h00;
         rst_meta_ff <= 1'b1;
         ram_rst_ff  <= 1'b1;
         bus_meta_ff <= '0;
         bus_ff      <= '0;
      end else if (ce) begin
         req_meta_ff <= ~{float_mem_req_n, transform_mem_req_n, filt2_mem_req_n,
                          filt1_mem_req_n, cpu_mem_req_n};
         req_act_ff  <= req_meta_ff;
         rst_meta_ff <= ram_dedicated_reset_n;
         ram_rst_ff  <= rst_meta_ff;
         bus_meta_ff <= '{rw_n: shared_read_write_n,
                          addr: ~shared_addr_n,
                          data: ~shared_data_n_rx};
         bus_ff      <= bus_meta_ff;
      end
   end

   // -------------------------------------------------------------
   // Arbiter and access sequencer
   // -------------------------------------------------------------
   ram_arb_pkg::arb_state_e st_ff, nxt_st;
   logic [15:0]             cnt_ff, nxt_cnt;
   logic [2:0]              owner_ff, nxt_owner;
   logic [4:0]              gnt_n_ff, nxt_gnt_n;
   logic                    rw_ff, nxt_rw;
   logic                    stb_ff, nxt_stb;
   logic [`RA_DATA_W-1:0]   dout_ff, nxt_dout;
   logic                    doe_ff, nxt_doe;
   logic                    irq_ff, nxt_irq;
   logic                    irq_n_ff, nxt_irq_n;
   logic                    mem_we;
   logic                    mem_re;
   logic [`RA_ADDR_W-1:0]   mem_addr;
   logic [`RA_DATA_W-1:0]   mem_wdata;
   logic [`RA_DATA_W-1:0]   mem_rdata;

   always_comb begin
      nxt_st    = st_ff;
      nxt_cnt   = cnt_ff;
      nxt_owner = owner_ff;
      nxt_gnt_n = gnt_n_ff;
      nxt_rw    = rw_ff;
      nxt_stb   = stb_ff;
      nxt_dout  = dout_ff;
      nxt_doe   = doe_ff;
      nxt_irq   = irq_ff;
      mem_we    = 1'b0;
      mem_re    = 1'b0;
      mem_addr  = bus_ff.addr;
      mem_wdata = bus_ff.data;
      unique case (st_ff)
         ram_arb_pkg::S_CLEAR: begin
            // Sweep writes zero everywhere; takes 2^16 cycles
            mem_we    = 1'b1;
            mem_addr  = cnt_ff;
            mem_wdata = '0;
            nxt_cnt   = cnt_ff + 16'h0001;
            if (cnt_ff == 16'hffff) begin
               nxt_st = ram_arb_pkg::S_IDLE;
            end
         end
         ram_arb_pkg::S_IDLE: begin
            if (|req_act_ff) begin
               nxt_owner = pick_next(req_act_ff, owner_ff);
               nxt_gnt_n = ~one_hot(nxt_owner);
               nxt_cnt   = `RA_CNT_RST;
               nxt_st    = ram_arb_pkg::S_GRANT;
            end
         end
         ram_arb_pkg::S_GRANT: begin
            nxt_cnt = cnt_ff + 16'h0001;
            // Bus is sampled after the 80 ns data-valid window plus sync delay
            if (cnt_ff == 16'(`RA_SAMPLE_CYC)) begin
               nxt_rw = bus_ff.rw_n;
               if (!bus_ff.rw_n) begin
                  mem_we = 1'b1;
                  if (bus_ff.addr == `RA_IRQ_ADDR) begin
                     nxt_irq = 1'b1;
                  end
               end else begin
                  mem_re = 1'b1;
                  if (bus_ff.addr == `RA_IRQ_ADDR) begin
                     nxt_irq = 1'b0;
                  end
               end
            end
            if (rw_ff && cnt_ff == 16'(`RA_SAMPLE_CYC + 1)) begin
               nxt_dout = ~mem_rdata;
               nxt_doe  = 1'b1;
               nxt_stb  = 1'b0;
            end
            if (cnt_ff == 16'(`RA_SAMPLE_CYC + 1 + `RA_SETUP_CYC)) begin
               nxt_stb = 1'b1;
            end
            if (cnt_ff == 16'(`RA_SAMPLE_CYC + 1 + `RA_SETUP_CYC + `RA_HOLD_CYC)) begin
               nxt_doe = 1'b0;
            end
            if (cnt_ff == 16'(`RA_GNT_CYC - 1)) begin
               nxt_gnt_n = `RA_GNT_RST;
               nxt_st    = ram_arb_pkg::S_RELEASE;
            end
         end
         ram_arb_pkg::S_RELEASE: begin
            // A stuck request would otherwise be granted twice for one need
            if (!req_act_ff[owner_ff]) begin
               nxt_st = ram_arb_pkg::S_IDLE;
            end
         end
      endcase
      if (!ram_rst_ff) begin
         nxt_st    = ram_arb_pkg::S_CLEAR;
         nxt_cnt   = `RA_CNT_RST;
         nxt_gnt_n = `RA_GNT_RST;
         nxt_stb   = 1'b1;
         nxt_doe   = 1'b0;
         nxt_irq   = 1'b0;
      end
      // Level pin gets its own flop so it never comes through an inverter
      nxt_irq_n = ~nxt_irq;
   end

   // System reset leaves memory alone; only the sweep clears it
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_ff    <= ram_arb_pkg::S_IDLE;
         cnt_ff   <= `RA_CNT_RST;
         owner_ff <= `RA_FLOAT_IDX;
         gnt_n_ff <= `RA_GNT_RST;
         rw_ff    <= 1'b1;
         stb_ff   <= 1'b1;
         dout_ff  <= '1;
         doe_ff   <= 1'b0;
         irq_ff   <= 1'b0;
         irq_n_ff <= 1'b1;
      end else if (ce) begin
         st_ff    <= nxt_st;
         cnt_ff   <= nxt_cnt;
         owner_ff <= nxt_owner;
         gnt_n_ff <= nxt_gnt_n;
         rw_ff    <= nxt_rw;
         stb_ff   <= nxt_stb;
         dout_ff  <= nxt_dout;
         doe_ff   <= nxt_doe;
         irq_ff   <= nxt_irq;
         irq_n_ff <= nxt_irq_n;
      end
   end

   ram_arb_mem #(
      .ADDR_W (`RA_ADDR_W),
      .DATA_W (`RA_DATA_W)
   ) u_mem (
      .sys_clk (sys_clk),
      .ce      (ce),
      .we      (mem_we),
      .re      (mem_re),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .rdata   (mem_rdata)
   );

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign cpu_mem_gnt_n        = gnt_n_ff[`RA_CPU_IDX];
   assign filt1_mem_gnt_n      = gnt_n_ff[`RA_FILT1_IDX];
   assign filt2_mem_gnt_n      = gnt_n_ff[`RA_FILT2_IDX];
   assign transform_mem_gnt_n  = gnt_n_ff[`RA_XFORM_IDX];
   assign float_mem_gnt_n      = gnt_n_ff[`RA_FLOAT_IDX];
   assign shared_data_n_tx     = dout_ff;
   assign shared_data_drive    = doe_ff;
   assign shared_data_strobe_n = stb_ff;
   assign ram_irq_n_level      = irq_n_ff;
   assign ram_irq_drive        = irq_ff;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_single_grant: assert property ($onehot0(~gnt_n_ff))
      else $error("more than one grant asserted");
   a_grant_cause: assert property (ce && st_ff == ram_arb_pkg::S_IDLE && ram_rst_ff
         && |req_act_ff |=> (~gnt_n_ff & req_act_ff) != 5'h00 || !ce)
      else $error("grant not given to a requester");
   a_grant_length: assert property ($rose(&gnt_n_ff) && st_ff == ram_arb_pkg::S_RELEASE
         |-> $past(cnt_ff) == 16'(`RA_GNT_CYC - 1))
      else $error("grant length wrong");
   a_release_wait: assert property (st_ff == ram_arb_pkg::S_RELEASE && req_act_ff[owner_ff]
         |=> &gnt_n_ff)
      else $error("new grant before request released");
   a_strobe_hold: assert property ($rose(stb_ff) && doe_ff |-> doe_ff[*3] ##1 !doe_ff)
      else $error("read data hold after strobe wrong");
   a_strobe_read: assert property ($fell(stb_ff) |-> rw_ff && doe_ff)
      else $error("strobe pulsed outside a read");
   a_write_quiet: assert property (st_ff == ram_arb_pkg::S_GRANT && !rw_ff |-> !doe_ff)
      else $error("data driven during a write");
   a_ded_reset: assert property (!ram_rst_ff && ce |=> st_ff == ram_arb_pkg::S_CLEAR
         && &gnt_n_ff && !irq_ff)
      else $error("dedicated reset not honoured");
   a_irq_raise: assert property (ce && ram_rst_ff && st_ff == ram_arb_pkg::S_GRANT
         && cnt_ff == 16'(`RA_SAMPLE_CYC) && !bus_ff.rw_n && bus_ff.addr == `RA_IRQ_ADDR
         |=> ram_irq_drive && !ram_irq_n_level)
      else $error("interrupt not raised");
   a_addr_read: assert property ($fell(stb_ff) |-> $past(mem_re, 2))
      else $error("read strobe without a memory read");

   c_cpu_grant:   cover property ($fell(cpu_mem_gnt_n));
   c_filt_grant:  cover property ($fell(filt1_mem_gnt_n) ##[1:200] $fell(filt2_mem_gnt_n));
   c_read_strobe: cover property ($rose(stb_ff));
   c_irq:         cover property ($rose(ram_irq_drive));

endmodule // global_ram_bus_arbiter

// ===== verif/requester_model.sv
// Behavioural bus master standing in for one requester of the shared RAM bus.
// Assumes one command at a time; start is sampled on a rising clock edge.
`timescale 1ns/1ps

module requester_model (
   input  wire logic                     sys_clk,
   input  wire logic                     start,
   input  wire ram_arb_pkg::bus_sample_s cmd,
   input  wire logic                     gnt_n,
   input  wire logic                     strobe_n,
   input  wire logic [15:0]              data_wire_n,
   output logic                          req_n,
   output logic                          rw_n,
   output logic      [16:1]              addr_n,
   output logic      [15:0]              data_n,
   output logic                          busy,
   output logic      [15:0]              rdata
);
   logic strobe_q = 1'b1;

   // ---------------------------------------------------------
   // Read capture
   // ---------------------------------------------------------
   // Data is taken only on the strobe's rising edge, never earlier
   always @(posedge sys_clk) begin
      if (strobe_n && !strobe_q)
         rdata <= ~data_wire_n;
      strobe_q <= strobe_n;
   end

   // ---------------------------------------------------------
   // Request, grant, transfer
   // ---------------------------------------------------------
   initial begin
      req_n  = 1'b1;
      rw_n   = 1'b1;
      addr_n = '1;
      data_n = '1;
      busy   = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (start) begin
            @(negedge sys_clk);
            busy  = 1'b1;
            req_n = 1'b0;
            do @(posedge sys_clk); while (gnt_n);
            @(negedge sys_clk);
            // Bus driven at once, well inside the data-valid window
            req_n  = 1'b1;
            rw_n   = cmd.rw_n;
            addr_n = ~cmd.addr;
            if (!cmd.rw_n)
               data_n = ~cmd.data;
            do @(posedge sys_clk); while (!gnt_n);
            @(negedge sys_clk);
            // Released open-collector lines float up to the pull-up level
            rw_n   = 1'b1;
            addr_n = '1;
            data_n = '1;
            busy   = 1'b0;
         end
      end
   end
endmodule // requester_model

// ===== verif/global_ram_bus_arbiter_tb.sv
// Self-checking bench for the global RAM arbiter with five requester models.
// Assumes the wired bus lines have pull-ups; clock enable drops once.
`timescale 1ns/1ps

module global_ram_bus_arbiter_tb;
   localparam int GNT_CYC = 51;
   logic                     sys_clk;
   logic                     nrst;
   logic                     ce;
   logic                     stuck_n;
   logic                     ram_dedicated_reset_n;
   logic [4:0]               start;
   ram_arb_pkg::bus_sample_s cmd [5];
   logic [4:0]               req_n;
   logic [4:0]               rw_m;
   logic [4:0]               busy;
   logic [4:0]               gnt_n;
   logic [4:0]               gnt_q;
   logic [16:1]              addr_m [5];
   logic [15:0]              data_m [5];
   logic [15:0]              rdata [5];
   logic [15:0]              tx_n;
   logic [15:0]              data_wire_n;
   logic [16:1]              addr_wire;
   logic                     rw_wire;
   logic                     drive;
   logic                     strobe_n;
   logic                     irq_level;
   logic                     irq_drive;
   int                       errors;
   int                       checks;
   int                       gnt_len;
   int                       last_len;
   int                       order[$];

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------
   // Wired bus: every party can only pull a line low
   // ---------------------------------------------------------
   always_comb begin
      data_wire_n = drive ? tx_n : 16'hffff;
      rw_wire     = 1'b1;
      addr_wire   = '1;
      for (int i = 0; i < 5; i++) begin
         data_wire_n &= data_m[i];
         rw_wire     &= rw_m[i];
         addr_wire   &= addr_m[i];
      end
   end

   global_ram_bus_arbiter i_global_ram_bus_arbiter (
      .sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .cpu_mem_req_n(req_n[0] & stuck_n), .filt1_mem_req_n(req_n[1]),
      .filt2_mem_req_n(req_n[2]),
      .transform_mem_req_n(req_n[3]), .float_mem_req_n(req_n[4]),
      .cpu_mem_gnt_n(gnt_n[0]), .filt1_mem_gnt_n(gnt_n[1]), .filt2_mem_gnt_n(gnt_n[2]),
      .transform_mem_gnt_n(gnt_n[3]), .float_mem_gnt_n(gnt_n[4]),
      .shared_read_write_n(rw_wire), .shared_addr_n(addr_wire),
      .shared_data_n_rx(data_wire_n), .shared_data_n_tx(tx_n), .shared_data_drive(drive),
      .shared_data_strobe_n(strobe_n), .ram_dedicated_reset_n(ram_dedicated_reset_n),
      .ram_irq_n_level(irq_level), .ram_irq_drive(irq_drive)
   );

   for (genvar gi = 0; gi < 5; gi++) begin : g_req
      requester_model i_req (
         .sys_clk(sys_clk), .start(start[gi]), .cmd(cmd[gi]), .gnt_n(gnt_n[gi]),
         .strobe_n(strobe_n), .data_wire_n(data_wire_n), .req_n(req_n[gi]),
         .rw_n(rw_m[gi]), .addr_n(addr_m[gi]), .data_n(data_m[gi]), .busy(busy[gi]),
         .rdata(rdata[gi])
      );
   end

   // ---------------------------------------------------------
   // Grant monitor: overlap, slot length, grant order
   // ---------------------------------------------------------
   always @(posedge sys_clk) begin
      if (nrst && $countones(~gnt_n) > 1) begin
         errors++;
         $display("[ERR] grants expected one low seen %b", gnt_n);
      end
      if (gnt_n != 5'h1f) gnt_len++;
      else if (gnt_len != 0) begin
         last_len = gnt_len;
         gnt_len  = 0;
      end
      for (int i = 0; i < 5; i++) if (gnt_q[i] && !gnt_n[i]) order.push_back(i);
      gnt_q <= gnt_n;
   end

   // ---------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------
   task automatic chk_bit(string name, logic exp, logic got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic chk_word(string name, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finish_test;
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Bounded wait: a transfer that never ends is a mismatch, not a hang
   task automatic wait_idle(int bound);
      int n;
      n = 0;
      while (busy != 5'h00 && n < bound) begin
         @(negedge sys_clk);
         n++;
      end
      if (busy != 5'h00) begin
         errors++;
         $display("[ERR] busy expected 00 seen %h", busy);
         finish_test();
      end
   endtask

   task automatic launch(int i, logic rw, logic [15:0] a, logic [15:0] d);
      cmd[i]   = '{rw, a, d};
      start[i] = 1'b1;
   endtask

   task automatic go(int bound);
      @(negedge sys_clk);
      start = 5'h00;
      @(negedge sys_clk);
      wait_idle(bound);
   endtask

   task automatic xfer(int i, logic rw, logic [15:0] a, logic [15:0] d);
      launch(i, rw, a, d);
      go(300);
   endtask

   // ---------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------
   task automatic t_reset;
      chk_word("grants", 16'h001f, {11'h000, gnt_n});
      chk_bit("strobe", 1'b1, strobe_n);
      chk_bit("drive", 1'b0, drive);
      chk_bit("irq_drive", 1'b0, irq_drive);
   endtask

   // A middle and two boundary addresses, a different reader than writer each time
   task automatic t_write_read;
      logic [15:0] adr [3] = '{16'h1234, 16'h0000, 16'hfffe};
      logic [15:0] dat [3] = '{16'ha5c3, 16'h5a3c, 16'hffff};
      for (int k = 0; k < 3; k++) begin
         xfer(k * 2, 1'b0, adr[k], dat[k]);
         chk_word("grant_len", 16'(GNT_CYC), 16'(last_len));
         xfer((k * 2 + 1) % 5, 1'b1, adr[k], 16'h0000);
         chk_word("read_data", dat[k], rdata[(k * 2 + 1) % 5]);
      end
   endtask

   // All five ask at once: each served once, in turn after the last owner
   task automatic t_rotation;
      int base;
      int last;
      base = order.size();
      last = order[base - 1];
      for (int i = 0; i < 5; i++) launch(i, 1'b0, 16'h0100 + 16'(i), 16'h1111 * 16'(i + 1));
      go(1000);
      for (int k = 0; k < 5; k++)
         chk_word("owner", 16'((last + 1 + k) % 5), 16'(order[base + k]));
   endtask

   task automatic t_irq;
      xfer(3, 1'b0, 16'hffff, 16'h0000);
      chk_bit("irq_drive", 1'b1, irq_drive);
      chk_bit("irq_level", 1'b0, irq_level);
      xfer(0, 1'b1, 16'hffff, 16'h0000);
      chk_bit("irq_drive", 1'b0, irq_drive);
      chk_bit("irq_level", 1'b1, irq_level);
   endtask

   // Clock enable low freezes the synchronisers and the arbiter alike
   task automatic t_freeze;
      ce = 1'b0;
      launch(3, 1'b0, 16'h0077, 16'h7777);
      @(negedge sys_clk);
      start = 5'h00;
      repeat (20) @(negedge sys_clk);
      chk_word("frozen_grants", 16'h001f, {11'h000, gnt_n});
      ce = 1'b1;
      wait_idle(300);
      xfer(2, 1'b1, 16'h0077, 16'h0000);
      chk_word("read_data", 16'h7777, rdata[2]);
   endtask

   // A request held past its slot must block every later grant
   task automatic t_stuck;
      stuck_n = 1'b0;
      repeat (120) @(negedge sys_clk);
      chk_word("stuck_grants", 16'h001f, {11'h000, gnt_n});
      launch(1, 1'b1, 16'h1234, 16'h0000);
      @(negedge sys_clk);
      start = 5'h00;
      repeat (60) @(negedge sys_clk);
      chk_word("held_grants", 16'h001f, {11'h000, gnt_n});
      chk_word("held_owner", 16'h0000, 16'(order[order.size() - 1]));
      stuck_n = 1'b1;
      wait_idle(300);
      chk_word("read_data", 16'ha5c3, rdata[1]);
   endtask

   // System reset keeps the RAM; only the dedicated line clears it
   task automatic t_resets;
      xfer(0, 1'b0, 16'h0042, 16'hbeef);
      nrst = 1'b0;
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      xfer(2, 1'b1, 16'h0042, 16'h0000);
      chk_word("kept_data", 16'hbeef, rdata[2]);
      xfer(1, 1'b0, 16'hffff, 16'h0000);
      ram_dedicated_reset_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk_bit("irq_drive", 1'b0, irq_drive);
      ram_dedicated_reset_n = 1'b1;
      // Sweep of every word takes a fixed count of cycles
      repeat (65600) @(negedge sys_clk);
      xfer(4, 1'b1, 16'h0042, 16'h0000);
      chk_word("cleared_data", 16'h0000, rdata[4]);
   endtask

   initial begin
      errors = 0;
      checks = 0;
      gnt_len = 0;
      last_len = 0;
      nrst = 1'b0;
      ce = 1'b1;
      stuck_n = 1'b1;
      ram_dedicated_reset_n = 1'b1;
      start = 5'h00;
      for (int i = 0; i < 5; i++) cmd[i] = '0;
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      t_reset();
      t_write_read();
      t_rotation();
      t_irq();
      t_freeze();
      t_stuck();
      t_resets();
      finish_test();
   end
endmodule // global_ram_bus_arbiter_tb
